// file: clk_sel_pkg.sv
/*
 Shared constants, register layouts and types of the system clock
 source selector.
 Assumes a 32-bit APB register bus and a single core clock.
*/
package clk_sel_pkg;

   // ***************************************************************
   // Register map
   // ***************************************************************
   localparam int APB_AW = 8;
   localparam logic [APB_AW-1:0] SYS_CTL_OFS = 8'h00;
   localparam logic [APB_AW-1:0] LOOP_CTL_OFS = 8'h04;
   localparam logic [APB_AW-1:0] PRESC_OFS = 8'h08;
   localparam logic [APB_AW-1:0] STATUS_OFS = 8'h0C;

   // ***************************************************************
   // Field widths and encodings
   // ***************************************************************
   localparam int PRESC_W = 10;
   localparam int IN_DIV_W = 6;
   localparam int MUL_W = 8;
   localparam int KDIV_W = 7;
   localparam int PER_W = 16;
   localparam int DIV_W = 32;
   localparam logic [1:0] SEL_DIRECT = 2'h3;
   localparam logic [1:0] SEL_DERIVED = 2'h2;

   // ***************************************************************
   // Register layouts, high bits first, low bits at the right
   // ***************************************************************
   typedef struct packed {
      logic ref_internal;
      logic [1:0] select;
   } sys_ctl_s;

   typedef struct packed {
      logic [KDIV_W-1:0] out_div;
      logic [MUL_W-1:0] mul;
      logic [IN_DIV_W-1:0] in_div;
      logic bypass;
   } loop_ctl_s;

   typedef struct packed {
      logic [PER_W-1:0] half_period;
      logic locked;
      logic sys_level;
      logic [1:0] select;
   } status_s;

   // ***************************************************************
   // Reset values
   // ***************************************************************
   localparam sys_ctl_s SYS_CTL_RST = '{ref_internal: 1'b0,
                                       select: SEL_DIRECT};
   localparam loop_ctl_s LOOP_CTL_RST = '{out_div: 7'h00, mul: 8'h00,
                                         in_div: 6'h00, bypass: 1'b1};
   localparam logic [PRESC_W-1:0] PRESC_RST = 10'h000;

   typedef enum logic [3:0] {
      LOOP_OFF = 4'b0001,
      LOOP_WAIT = 4'b0010,
      LOOP_TRACK = 4'b0100,
      LOOP_LOCK = 4'b1000
   } loop_state_e;

endpackage

// file: edge_period_meter.sv
/*
 Registers a sampled clock level, flags its rising edges and measures
 the number of core cycles between two rising edges.
 Assumes the level is synchronous to the core clock.
*/
`timescale 1ns/1ps
`default_nettype none
module edge_period_meter #(
   parameter int CNT_W = 16
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic level_i,
   output logic level_o,
   output logic rise_o,
   output logic [CNT_W-1:0] period_o,
   output logic valid_o
);
   logic [CNT_W-1:0] count;
   logic seen;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         level_o <= 1'b0;
      end else begin
         level_o <= level_i;
      end
   end

   assign rise_o = level_i & ~level_o;

   // Period counter saturates on a stalled source
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count <= '0;
         seen <= 1'b0;
         period_o <= '0;
         valid_o <= 1'b0;
      end else begin
         valid_o <= 1'b0;
         if (rise_o) begin
            count <= CNT_W'(1);
            seen <= 1'b1;
            if (seen) begin
               period_o <= count;
               valid_o <= 1'b1;
            end
         end else if (count != '1) begin
            count <= count + CNT_W'(1);
         end
      end
   end
endmodule
`default_nettype wire

// file: seq_divider.sv
/*
 Restoring unsigned divider, one quotient bit per core cycle.
 Assumes a non-zero divisor and a start only while idle.
*/
`timescale 1ns/1ps
`default_nettype none
module seq_divider #(
   parameter int W = 32
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic start_i,
   input wire logic [W-1:0] dividend_i,
   input wire logic [W-1:0] divisor_i,
   output logic busy_o,
   output logic done_o,
   output logic [W-1:0] quotient_o
);
   logic [W-1:0] rem;
   logic [W-1:0] dsr;
   logic [W-1:0] quo;
   logic [$clog2(W+1)-1:0] steps;
   logic [W:0] trial;

   assign trial = {rem, quo[W-1]};

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rem <= '0;
         dsr <= '0;
         quo <= '0;
         steps <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
         quotient_o <= '0;
      end else begin
         done_o <= 1'b0;
         if (start_i && !busy_o) begin
            rem <= '0;
            quo <= dividend_i;
            dsr <= divisor_i;
            steps <= ($clog2(W+1))'(W);
            busy_o <= 1'b1;
         end else if (busy_o) begin
            if (trial >= {1'b0, dsr}) begin
               rem <= W'(trial - {1'b0, dsr});
               quo <= {quo[W-2:0], 1'b1};
            end else begin
               rem <= trial[W-1:0];
               quo <= {quo[W-2:0], 1'b0};
            end
            steps <= steps - 1'b1;
            if (steps == 1) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
               quotient_o <= (trial >= {1'b0, dsr}) ?
                             {quo[W-2:0], 1'b1} : {quo[W-2:0], 1'b0};
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: system_clock_source_select.sv
/*
 System clock source selector: direct drive, prescaler and a digital
 model of the loop multiplier, configured over APB.
 Assumes all clock inputs are sampled levels synchronous to core_clk_i
 and well below half its rate.
*/
// Our own choices: the APB slave port and the address map.
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [clk_sel_pkg::APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   input wire logic direct_clock_input_i,
   input wire logic crystal_input_i,
   input wire logic internal_clock_i,
   output logic sys_clk_o,
   output logic loop_locked_o
);
   import clk_sel_pkg::*;

   // ***************************************************************
   // Declarations
   // ***************************************************************
   sys_ctl_s sys_ctl;
   loop_ctl_s loop_ctl;
   logic [PRESC_W-1:0] prescaler_divide_value;
   status_s status;
   logic access;
   logic do_write;
   logic [31:0] next_rdata;
   logic next_err;
   logic ref_level;
   logic ref_q;
   logic ref_rise;
   logic [PER_W-1:0] ref_period;
   logic period_valid;
   logic [PRESC_W-1:0] presc_cnt;
   logic [PRESC_W-1:0] next_presc_cnt;
   logic presc_level;
   logic loop_en;
   loop_state_e state;
   logic [DIV_W-1:0] numer;
   logic [DIV_W-1:0] denom;
   logic div_busy;
   logic div_done;
   logic [DIV_W-1:0] quotient;
   logic [PER_W-1:0] next_target;
   logic [PER_W-1:0] target;
   logic [PER_W-1:0] cur;
   logic [PER_W-1:0] loop_cnt;
   logic loop_level;
   logic loop_run;
   logic next_sys;

   // ***************************************************************
   // APB slave, two-cycle access phase
   // ***************************************************************
   assign access = psel_i & penable_i;
   assign do_write = access & pready_o & pwrite_i;
   assign status = '{half_period: cur, locked: loop_locked_o,
                     sys_level: sys_clk_o, select: sys_ctl.select};

   // Unmapped offsets answer with an error and zero data
   always_comb begin
      next_rdata = 32'h0000_0000;
      next_err = 1'b0;
      case (paddr_i)
         SYS_CTL_OFS: next_rdata = 32'(sys_ctl);
         LOOP_CTL_OFS: next_rdata = 32'(loop_ctl);
         PRESC_OFS: next_rdata = 32'(prescaler_divide_value);
         STATUS_OFS: next_rdata = 32'(status);
         default: next_err = 1'b1;
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         pready_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else begin
         pready_o <= access & ~pready_o;
         if (access && !pready_o) begin
            prdata_o <= pwrite_i ? 32'h0000_0000 : next_rdata;
            pslverr_o <= next_err;
         end else begin
            prdata_o <= 32'h0000_0000;
            pslverr_o <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // Configuration registers, written at the ready edge
   // ***************************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sys_ctl <= SYS_CTL_RST;
         loop_ctl <= LOOP_CTL_RST;
         prescaler_divide_value <= PRESC_RST;
      end else if (do_write) begin
         case (paddr_i)
            SYS_CTL_OFS: sys_ctl <= sys_ctl_s'(pwdata_i[$bits(sys_ctl_s)-1:0]);
            LOOP_CTL_OFS:
               loop_ctl <= loop_ctl_s'(pwdata_i[$bits(loop_ctl_s)-1:0]);
            PRESC_OFS:
               prescaler_divide_value <= pwdata_i[PRESC_W-1:0];
            default: ;
         endcase
      end
   end

   // ***************************************************************
   // Reference source and its period
   // ***************************************************************
   assign ref_level = sys_ctl.ref_internal ?
                      internal_clock_i : crystal_input_i;

   edge_period_meter #(
      .CNT_W(PER_W)
   ) u_ref_meter (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .level_i(ref_level),
      .level_o(ref_q),
      .rise_o(ref_rise),
      .period_o(ref_period),
      .valid_o(period_valid)
   );

   // ***************************************************************
   // Prescaler: factor is divide value plus one, up to 1024
   // ***************************************************************
   // Wrap early if the divide value shrinks below the count
   always_comb begin
      next_presc_cnt = presc_cnt + PRESC_W'(1);
      if (presc_cnt >= prescaler_divide_value) begin
         next_presc_cnt = '0;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         presc_cnt <= '0;
      end else if (ref_rise) begin
         presc_cnt <= next_presc_cnt;
      end
   end

   // High for the first half of each output period
   assign presc_level = (presc_cnt <= (prescaler_divide_value >> 1));

   // ***************************************************************
   // Loop multiplier target: half period = T*P*K2 / (2*N)
   // ***************************************************************
   // Loop runs only in derived mode with the bypass off
   assign loop_en = (sys_ctl.select == SEL_DERIVED) & ~loop_ctl.bypass;
   assign numer = DIV_W'(ref_period) *
                  (DIV_W'(loop_ctl.in_div) + DIV_W'(1)) *
                  (DIV_W'(loop_ctl.out_div) + DIV_W'(1));
   assign denom = (DIV_W'(loop_ctl.mul) + DIV_W'(1)) << 1;

   // In loop mode, target is recomputed on each measured reference period that finds the divider idle
   seq_divider #(
      .W(DIV_W)
   ) u_div (
      .clk_i(core_clk_i),
      .rst_i(rst_i),
      .start_i(loop_en & period_valid),
      .dividend_i(numer),
      .divisor_i(denom),
      .busy_o(div_busy),
      .done_o(div_done),
      .quotient_o(quotient)
   );

   // Clamp the quotient into the half-period counter's range
   always_comb begin
      next_target = quotient[PER_W-1:0];
      if (quotient == '0) begin
         next_target = PER_W'(1);
      end else if (quotient > DIV_W'({PER_W{1'b1}})) begin
         next_target = '1;
      end
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         target <= '1;
      end else if (div_done) begin
         target <= next_target;
      end
   end

   // ***************************************************************
   // Loop state
   // ***************************************************************
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         state <= LOOP_OFF;
      end else if (!loop_en) begin
         state <= LOOP_OFF;
      end else begin
         case (state)
            LOOP_OFF: state <= LOOP_WAIT;
            LOOP_WAIT: begin
               if (div_done) begin
                  state <= LOOP_TRACK;
               end
            end
            LOOP_TRACK: begin
               if (cur == target) begin
                  state <= LOOP_LOCK;
               end
            end
            LOOP_LOCK: begin
               if (cur != target) begin
                  state <= LOOP_TRACK;
               end
            end
            default: state <= LOOP_OFF;
         endcase
      end
   end

   // ***************************************************************
   // Loop oscillator, half period slewed one step per half cycle
   // ***************************************************************
   assign loop_run = (state == LOOP_TRACK) | (state == LOOP_LOCK);

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         cur <= '1;
         loop_cnt <= '0;
         loop_level <= 1'b0;
      end else if (!loop_run) begin
         cur <= '1;
         loop_cnt <= '0;
         loop_level <= 1'b0;
      end else if (loop_cnt + PER_W'(1) >= cur) begin
         loop_cnt <= '0;
         loop_level <= ~loop_level;
         if (cur > target) begin
            cur <= cur - PER_W'(1);
         end else if (cur < target) begin
            cur <= cur + PER_W'(1);
         end
      end else begin
         loop_cnt <= loop_cnt + PER_W'(1);
      end
   end

   // ***************************************************************
   // System clock selection
   // ***************************************************************
   always_comb begin
      next_sys = internal_clock_i;
      if (sys_ctl.select == SEL_DIRECT) begin
         next_sys = direct_clock_input_i;
      end else if (sys_ctl.select == SEL_DERIVED) begin
         if (!loop_ctl.bypass) begin
            next_sys = loop_level;
         end else if (prescaler_divide_value == '0) begin
            next_sys = ref_q;
         end else begin
            next_sys = presc_level;
         end
      end
   end

   // ***************************************************************
   // Output registers
   // ***************************************************************
   // Lock flag lags the loop state by one cycle
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sys_clk_o <= 1'b0;
         loop_locked_o <= 1'b0;
      end else begin
         sys_clk_o <= next_sys;
         loop_locked_o <= (state == LOOP_LOCK);
      end
   end
endmodule
`default_nettype wire

// file: system_clock_source_select_asserts.sv
/*
 Port checker for the system clock source selector, bound to its top.
 Assumes clock inputs are levels synchronous to core_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_asserts (
   input wire logic core_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [clk_sel_pkg::APB_AW-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic direct_clock_input_i,
   input wire logic crystal_input_i,
   input wire logic internal_clock_i,
   input wire logic sys_clk_o,
   input wire logic loop_locked_o
);
   import clk_sel_pkg::*;
   // ***************************************************************
   // Shadow of the configuration, taken from completed writes
   // ***************************************************************
   logic [1:0] sel;
   logic ref_int;
   logic bypass;
   logic [9:0] presc;
   logic [3:0] quiet;
   logic [3:0] ref_h;
   logic wr_go;
   logic ref_lvl;
   logic mapped;
   logic settled;
   logic presc_mode;
   assign wr_go = psel_i && penable_i && pready_o && pwrite_i;
   assign ref_lvl = ref_int ? internal_clock_i : crystal_input_i;
   assign mapped = paddr_i inside {SYS_CTL_OFS, LOOP_CTL_OFS, PRESC_OFS,
      STATUS_OFS};
   assign settled = quiet >= 4'h4;
   assign presc_mode = settled && sel == SEL_DERIVED && bypass;
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         sel <= SEL_DIRECT;
         ref_int <= 1'h0;
         bypass <= 1'h1;
         presc <= 10'h000;
      end else if (wr_go && paddr_i == SYS_CTL_OFS) begin
         sel <= pwdata_i[1:0];
         ref_int <= pwdata_i[2];
      end else if (wr_go && paddr_i == LOOP_CTL_OFS) begin
         bypass <= pwdata_i[0];
      end else if (wr_go && paddr_i == PRESC_OFS) begin
         presc <= pwdata_i[9:0];
      end
   end
   // Cycles since the last completed write, saturating
   always_ff @(posedge core_clk_i) begin
      if (rst_i || wr_go) begin
         quiet <= 4'h0;
      end else if (quiet != 4'hF) begin
         quiet <= quiet + 4'h1;
      end
   end
   always_ff @(posedge core_clk_i) begin
      ref_h <= {ref_h[2:0], ref_lvl};
   end
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   a_ready_answer: assert property (psel_i && penable_i && !pready_o
      |=> pready_o) else $error("ready late");
   a_ready_pulse: assert property (pready_o |=> !pready_o)
      else $error("ready held");
   a_err_unmapped: assert property (pready_o |-> pslverr_o == !mapped)
      else $error("error flag wrong");
   a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("read data outside ready");
   a_err_zero: assert property (pready_o && pslverr_o
      |-> prdata_o == 32'h0) else $error("error read not zero");
   a_direct_follow: assert property (settled && sel == SEL_DIRECT
      |-> sys_clk_o == $past(direct_clock_input_i)) else $error("direct");
   a_presc_unity: assert property (presc_mode && presc == 10'h000
      |-> sys_clk_o == $past(ref_lvl, 2)) else $error("unity prescale");
   a_presc_edge: assert property (presc_mode && presc != 10'h000
      && $changed(sys_clk_o) |-> (ref_h[0] && !ref_h[1])
      || (ref_h[1] && !ref_h[2]) || (ref_h[2] && !ref_h[3]))
      else $error("prescaler toggles off reference edge");
   a_lock_mode: assert property (settled && !(sel == SEL_DERIVED
      && !bypass) |-> !loop_locked_o) else $error("lock outside loop");
   cover property (presc_mode && presc != 10'h000 && $changed(sys_clk_o));
   cover property ($rose(loop_locked_o));
   cover property (pready_o && pslverr_o);
endmodule
bind system_clock_source_select system_clock_source_select_asserts
   system_clock_source_select_asserts_i (.core_clk_i(core_clk_i),
   .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
   .pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
   .direct_clock_input_i(direct_clock_input_i),
   .crystal_input_i(crystal_input_i), .internal_clock_i(internal_clock_i),
   .sys_clk_o(sys_clk_o), .loop_locked_o(loop_locked_o));
`default_nettype wire

// file: osc_model.sv
/*
 Free-running clock source with run-time high and low times.
 Assumes both times are at least one core cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module osc_model (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [9:0] hi_i,
   input wire logic [9:0] lo_i,
   output logic osc_o
);
   logic [9:0] cnt;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt <= 10'h000;
         osc_o <= 1'h0;
      end else if (cnt + 10'h001 >= (osc_o ? hi_i : lo_i)) begin
         cnt <= 10'h000;
         osc_o <= !osc_o;
      end else begin
         cnt <= cnt + 10'h001;
      end
   end
endmodule
`default_nettype wire

// file: system_clock_source_select_bench.sv
/*
 Self-checking bench for the system clock source selector.
 Assumes the package constants and the APB timing of the block.
*/
`timescale 1ns/1ps
`default_nettype none
module system_clock_source_select_bench;
   import clk_sel_pkg::*;
   logic clk, rst, psel, pen, pwr, pready, pslverr, dclk, xclk, iclk;
   logic sclk, lock;
   logic [APB_AW-1:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [9:0] dh, dl, xh, xl, ih, il;
   int err_total = 0;
   int samples_checked = 0;
   system_clock_source_select system_clock_source_select_i (
      .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen),
      .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
      .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr),
      .direct_clock_input_i(dclk), .crystal_input_i(xclk),
      .internal_clock_i(iclk), .sys_clk_o(sclk), .loop_locked_o(lock));
   osc_model osc_model_d (.clk_i(clk), .rst_i(rst), .hi_i(dh), .lo_i(dl),
      .osc_o(dclk));
   osc_model osc_model_x (.clk_i(clk), .rst_i(rst), .hi_i(xh), .lo_i(xl),
      .osc_o(xclk));
   osc_model osc_model_n (.clk_i(clk), .rst_i(rst), .hi_i(ih), .lo_i(il),
      .osc_o(iclk));
   // ***************************************************************
   // Shared tasks
   // ***************************************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic e);
      @(posedge clk);
      psel <= 1'h1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'h1;
      @(posedge clk);
      while (pready !== 1'h1) @(posedge clk);
      q = prdata;
      e = pslverr;
      psel <= 1'h0;
      pen <= 1'h0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'h1, a, d, q, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic xe,
      output logic [31:0] q);
      logic e;
      apb(1'h0, a, 32'h0, q, e);
      chk({31'h0, e}, {31'h0, xe});
   endtask
   // High time and period of the system clock, in core cycles
   task automatic meas(output logic [31:0] hi, output logic [31:0] per);
      hi = 32'h0;
      @(posedge clk);
      while (sclk !== 1'h1) @(posedge clk);
      while (sclk !== 1'h0) @(posedge clk);
      while (sclk !== 1'h1) @(posedge clk);
      while (sclk === 1'h1) begin
         @(posedge clk);
         hi++;
      end
      per = hi;
      while (sclk === 1'h0) begin
         @(posedge clk);
         per++;
      end
   endtask
   // ***************************************************************
   // Scenarios
   // ***************************************************************
   task automatic t_regs;
      logic [31:0] q;
      rd(SYS_CTL_OFS, 1'h0, q);
      chk(q, 32'h3);
      rd(LOOP_CTL_OFS, 1'h0, q);
      chk(q, 32'h1);
      rd(8'h10, 1'h1, q);
      chk(q, 32'h0);
      wr(PRESC_OFS, 32'hFFFFFFFF);
      rd(PRESC_OFS, 1'h0, q);
      chk(q, 32'h3FF);
      $display("test regs done");
   endtask
   task automatic t_direct;
      logic [31:0] h, p;
      meas(h, p);
      chk(h, 32'h3);
      chk(p, 32'h5);
      wr(SYS_CTL_OFS, 32'h0);
      meas(h, p);
      chk(h, 32'h2);
      chk(p, 32'h5);
      $display("test direct done");
   endtask
   task automatic t_unity;
      logic [31:0] h, p;
      wr(PRESC_OFS, 32'h0);
      wr(SYS_CTL_OFS, 32'h2);
      meas(h, p);
      chk(h, 32'h4);
      chk(p, 32'h6);
      wr(SYS_CTL_OFS, 32'h6);
      meas(h, p);
      chk(h, 32'h2);
      chk(p, 32'h5);
      $display("test unity done");
   endtask
   task automatic t_div;
      logic [31:0] h, p;
      wr(PRESC_OFS, 32'h2);
      meas(h, p);
      meas(h, p);
      chk(p, 32'hF);
      wr(PRESC_OFS, 32'h3FF);
      meas(h, p);
      meas(h, p);
      chk(p, 32'h1400);
      $display("test divide done");
   endtask
   task automatic t_loop;
      logic [31:0] q;
      logic s0;
      int n;
      n = 0;
      xh <= 10'h101;
      xl <= 10'h101;
      wr(SYS_CTL_OFS, 32'h2);
      wr(LOOP_CTL_OFS, 32'h0010809C);
      while (lock !== 1'h1 && n < 3000) begin
         @(posedge clk);
         n++;
      end
      chk({31'h0, lock}, 32'h1);
      rd(STATUS_OFS, 1'h0, q);
      chk(q & 32'h000FFFFB, 32'h000FFFFA);
      wr(LOOP_CTL_OFS, 32'h0010809A);
      s0 = sclk;
      repeat (3000) @(posedge clk);
      chk({31'h0, lock}, 32'h0);
      chk({31'h0, sclk}, {31'h0, s0});
      rd(STATUS_OFS, 1'h0, q);
      chk(q & 32'h000FFFFB, 32'h000FFFF2);
      $display("test loop done");
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   initial begin
      clk = 1'h0;
      forever #2 clk = ~clk;
   end
   initial begin
      repeat (60000) @(posedge clk);
      err_total++;
      close_out;
   end
   initial begin
      {rst, psel, pen, pwr, paddr, pwdata} = {3'h4, 1'h0, 8'h00, 32'h0};
      {dh, dl, xh, xl, ih, il} = {10'h3, 10'h2, 10'h4, 10'h2, 10'h2, 10'h3};
      repeat (6) @(posedge clk);
      rst <= 1'h0;
      t_regs;
      t_direct;
      t_unity;
      t_div;
      t_loop;
      close_out;
   end
endmodule
`default_nettype wire
